// ==== sslp_cfg.svh ====
// Constants for the synthesizer serial load port
`ifndef SSLP_CFG_SVH
`define SSLP_CFG_SVH
// ----------------------------------------
// Shift word and latch select
// ----------------------------------------
`define SSLP_WORD_W 24
`define SSLP_SEL_LSB 0
`define SSLP_SEL_W 2
`define SSLP_NUM_LATCH 4
`define SSLP_LATCH_IF_REF 2'h0
`define SSLP_LATCH_IF_FB 2'h1
`define SSLP_LATCH_RF_REF 2'h2
`define SSLP_LATCH_RF_FB 2'h3
`define SSLP_WORD_RST 24'h000000
// ----------------------------------------
// Output select fields, held in the IF reference latch
// ----------------------------------------
`define SSLP_OBS_SEL_MSB 23
`define SSLP_OBS_SEL_LSB 22
`define SSLP_LOCK_SRC_BIT 21
`define SSLP_FAST_SEL_MSB 20
`define SSLP_FAST_SEL_LSB 19
// ----------------------------------------
// Lock detect thresholds and counts
// ----------------------------------------
`define SSLP_ERR_W 8
`define SSLP_LOCK_SET_NS 8'h0F
`define SSLP_LOCK_CLR_NS 8'h19
`define SSLP_LOCK_CYCLES 2'h3
`endif

// ==== sslp_host_model.sv ====
// Host model that drives the three serial load pins
`timescale 1ns/1ps
module sslp_host_model (
   // Serial pins toward the port
   output logic ser_clk_out,
   output logic ser_data_out,
   output logic load_strobe_out
);
   initial begin
      ser_clk_out = 1'b0;
      ser_data_out = 1'b0;
      load_strobe_out = 1'b0;
   end
   // Clock stands low between frames; data turns over on the fall, so hold is the full 100 ns high time
   task automatic send(input logic [23:0] w, input int low_ns, input bit load);
      for (int i = 23; i >= 0; i--) begin
         ser_data_out = w[i];
         #(low_ns) ser_clk_out = 1'b1;
         #100 ser_clk_out = 1'b0;
      end
      // Released data shows the inverse so a stale bit cannot pass
      ser_data_out = ~w[0];
      #100 load_strobe_out = load;
      #100 load_strobe_out = 1'b0;
   endtask
endmodule // sslp_host_model

// ==== sslp_pkg.sv ====
// Types for the synthesizer serial load port
package sslp_pkg;
   typedef logic [23:0] sslp_word_t;
   typedef enum logic [1:0] {SSLP_OBS_LOCK, SSLP_OBS_RF_DIV, SSLP_OBS_IF_DIV, SSLP_OBS_REF_DIV} sslp_obs_e;
   typedef enum logic [1:0] {SSLP_FAST_MODE, SSLP_FAST_RF_N, SSLP_FAST_RF_R, SSLP_FAST_IF_R} sslp_fast_e;
endpackage

// ==== sslp_port.sv ====
// Serial load port: shift register, four latches, lock detect and output muxes
`timescale 1ns/1ps
`include "sslp_cfg.svh"
// Behaviour
// - Shift data in on each serial clock rise
// - Most significant bit first; last is bit0
// - Two lowest bits select the latch
// - Strobe rise copies word into selected latch
// - Observation output shows one selected signal
// - Fast-settle output muxes dividers and fast mode
// - Code 0 IF reference, 1 IF feedback
// - Lock after three good cycles, drop on error above the clear threshold
module sslp_port (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic sys_rst_in,
   // Serial pins from the host
   input wire logic ser_clk_in,
   input wire logic ser_data_in,
   input wire logic load_strobe_in,
   // Internal divider and control signals
   input wire logic rf_ndiv_in,
   input wire logic rf_rdiv_in,
   input wire logic if_ndiv_in,
   input wire logic if_rdiv_in,
   input wire logic ref_div_in,
   input wire logic fast_mode_in,
   // Phase detector results, one pulse per detector cycle
   input wire logic rf_pd_strobe_in,
   input wire logic [`SSLP_ERR_W-1:0] rf_pd_err_in,
   input wire logic if_pd_strobe_in,
   input wire logic [`SSLP_ERR_W-1:0] if_pd_err_in,
   // Latch contents
   output sslp_pkg::sslp_word_t if_ref_latch_out,
   output sslp_pkg::sslp_word_t if_fb_latch_out,
   output sslp_pkg::sslp_word_t rf_ref_latch_out,
   output sslp_pkg::sslp_word_t rf_fb_latch_out,
   // Observation pins
   output logic rf_lock_out,
   output logic if_lock_out,
   output logic observe_output_out,
   output logic fast_settle_output_out
);
   import sslp_pkg::*;

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   // Data is delayed as far as the clock so a rise samples the bit it framed
   logic [2:0] sclk_q, sclk_d;
   logic [1:0] sdat_q, sdat_d;
   logic [2:0] le_q, le_d;
   logic sclk_rise, le_rise;

   always_comb begin
      sclk_d = {sclk_q[1:0], ser_clk_in};
      sdat_d = {sdat_q[0], ser_data_in};
      le_d = {le_q[1:0], load_strobe_in};
   end

   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         sclk_q <= 3'h0;
         sdat_q <= 2'h0;
         le_q <= 3'h0;
      end else begin
         sclk_q <= sclk_d;
         sdat_q <= sdat_d;
         le_q <= le_d;
      end
   end

   assign sclk_rise = sclk_q[1] & ~sclk_q[2];
   assign le_rise = le_q[1] & ~le_q[2];

   // ----------------------------------------
   // Shift register and latches
   // ----------------------------------------
   sslp_word_t shift_q, shift_d;
   sslp_word_t latch_q [`SSLP_NUM_LATCH];
   sslp_word_t latch_d [`SSLP_NUM_LATCH];
   logic [`SSLP_SEL_W-1:0] sel;

   // The select bits are the last two shifted in
   assign sel = shift_q[`SSLP_SEL_LSB +: `SSLP_SEL_W];

   always_comb begin
      shift_d = shift_q;
      if (sclk_rise) begin
         shift_d = {shift_q[`SSLP_WORD_W-2:0], sdat_q[1]};
      end
      for (int i = 0; i < `SSLP_NUM_LATCH; i++) begin
         latch_d[i] = latch_q[i];
         if (le_rise && (sel == i[`SSLP_SEL_W-1:0])) begin
            latch_d[i] = shift_q;
         end
      end
   end

   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         shift_q <= `SSLP_WORD_RST;
         for (int i = 0; i < `SSLP_NUM_LATCH; i++) begin
            latch_q[i] <= `SSLP_WORD_RST;
         end
      end else begin
         shift_q <= shift_d;
         for (int i = 0; i < `SSLP_NUM_LATCH; i++) begin
            latch_q[i] <= latch_d[i];
         end
      end
   end

   assign if_ref_latch_out = latch_q[`SSLP_LATCH_IF_REF];
   assign if_fb_latch_out = latch_q[`SSLP_LATCH_IF_FB];
   assign rf_ref_latch_out = latch_q[`SSLP_LATCH_RF_REF];
   assign rf_fb_latch_out = latch_q[`SSLP_LATCH_RF_FB];

   // ----------------------------------------
   // Digital lock detect, index 0 RF and 1 IF
   // ----------------------------------------
   logic [1:0] pd_stb;
   logic [`SSLP_ERR_W-1:0] pd_err [2];
   logic [1:0] good_cnt_q [2];
   logic [1:0] good_cnt_d [2];
   logic [1:0] lock_q, lock_d;

   assign pd_stb = {if_pd_strobe_in, rf_pd_strobe_in};
   assign pd_err[0] = rf_pd_err_in;
   assign pd_err[1] = if_pd_err_in;

   always_comb begin
      for (int i = 0; i < 2; i++) begin
         good_cnt_d[i] = good_cnt_q[i];
         lock_d[i] = lock_q[i];
         if (pd_stb[i]) begin
            if (pd_err[i] < `SSLP_LOCK_SET_NS) begin
               if (good_cnt_q[i] != `SSLP_LOCK_CYCLES) begin
                  good_cnt_d[i] = good_cnt_q[i] + 2'h1;
               end
            end else begin
               good_cnt_d[i] = 2'h0;
            end
            if (pd_err[i] > `SSLP_LOCK_CLR_NS) begin
               lock_d[i] = 1'b0;
            end else if (good_cnt_d[i] == `SSLP_LOCK_CYCLES) begin
               lock_d[i] = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         good_cnt_q[0] <= 2'h0;
         good_cnt_q[1] <= 2'h0;
         lock_q <= 2'h0;
      end else begin
         good_cnt_q <= good_cnt_d;
         lock_q <= lock_d;
      end
   end

   assign rf_lock_out = lock_q[0];
   assign if_lock_out = lock_q[1];

   // ----------------------------------------
   // Observation and fast-settle multiplexers
   // ----------------------------------------
   // Outputs are registered, so each lags its source by one cycle
   sslp_obs_e obs_sel;
   sslp_fast_e fast_sel;
   logic obs_q, obs_d, fast_q, fast_d;

   assign obs_sel = sslp_obs_e'(latch_q[`SSLP_LATCH_IF_REF][`SSLP_OBS_SEL_MSB:`SSLP_OBS_SEL_LSB]);
   assign fast_sel = sslp_fast_e'(latch_q[`SSLP_LATCH_IF_REF][`SSLP_FAST_SEL_MSB:`SSLP_FAST_SEL_LSB]);

   always_comb begin
      case (obs_sel)
         SSLP_OBS_LOCK: obs_d = latch_q[`SSLP_LATCH_IF_REF][`SSLP_LOCK_SRC_BIT] ? lock_q[1] : lock_q[0];
         SSLP_OBS_RF_DIV: obs_d = rf_ndiv_in;
         SSLP_OBS_IF_DIV: obs_d = if_ndiv_in;
         SSLP_OBS_REF_DIV: obs_d = ref_div_in;
         default: obs_d = 1'b0;
      endcase
      case (fast_sel)
         SSLP_FAST_MODE: fast_d = fast_mode_in;
         SSLP_FAST_RF_N: fast_d = rf_ndiv_in;
         SSLP_FAST_RF_R: fast_d = rf_rdiv_in;
         SSLP_FAST_IF_R: fast_d = if_rdiv_in;
         default: fast_d = 1'b0;
      endcase
   end

   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         obs_q <= 1'b0;
         fast_q <= 1'b0;
      end else begin
         obs_q <= obs_d;
         fast_q <= fast_d;
      end
   end

   assign observe_output_out = obs_q;
   assign fast_settle_output_out = fast_q;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   sequence rf_good_s;
      rf_pd_strobe_in && (rf_pd_err_in < `SSLP_LOCK_SET_NS);
   endsequence
   // Good cycles must be consecutive detector cycles: only a strobe-free cycle may sit between them,
   // otherwise a bad cycle in the gap would reset the count and the property would fire falsely
   sequence rf_three_good_s;
      rf_good_s ##1 !rf_pd_strobe_in ##1 rf_good_s ##1 !rf_pd_strobe_in ##1 rf_good_s;
   endsequence

   shift_in_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
      sclk_rise |=> shift_q == {$past(shift_q[22:0]), $past(sdat_q[1])})
      else $error("shift register did not take the serial bit");
   shift_idle_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
      !sclk_rise |=> $stable(shift_q))
      else $error("shift register moved without a clock rise");
   latch_load_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
      le_rise |=> latch_q[$past(sel)] == $past(shift_q))
      else $error("selected latch not loaded");
   ifref_map_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
      le_rise && shift_q[1:0] == 2'h0 |=> if_ref_latch_out == $past(shift_q) && $stable(if_fb_latch_out))
      else $error("code zero did not load only the IF reference latch");
   iffb_map_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
      le_rise && shift_q[1:0] == 2'h1 |=> if_fb_latch_out == $past(shift_q) && $stable(rf_fb_latch_out))
      else $error("code one did not load only the IF feedback latch");
   latch_hold_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
      !le_rise |=> $stable(rf_ref_latch_out) && $stable(rf_fb_latch_out) && $stable(if_fb_latch_out))
      else $error("latch changed without a strobe rise");
   lock_set_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
      rf_three_good_s |=> rf_lock_out)
      else $error("lock not set after three good detector cycles");
   lock_clear_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
      rf_pd_strobe_in && rf_pd_err_in > `SSLP_LOCK_CLR_NS |=> !rf_lock_out)
      else $error("lock not cleared by a large phase error");
   lock_rise_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
      $rose(rf_lock_out) |-> $past(rf_pd_strobe_in) && $past(rf_pd_err_in) < `SSLP_LOCK_SET_NS)
      else $error("lock rose without a good detector cycle");
   observe_mux_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
      obs_sel == SSLP_OBS_REF_DIV |=> observe_output_out == $past(ref_div_in))
      else $error("observation output not following the reference divider");
   fast_mux_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
      fast_sel == SSLP_FAST_MODE |=> fast_settle_output_out == $past(fast_mode_in))
      else $error("fast-settle output not following the fast mode control");
endmodule // sslp_port

// ==== testbench.sv ====
// Self-checking bench for the serial load port
`timescale 1ns/1ps
module testbench;
   import sslp_pkg::*;
   logic mclk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic ser_clk, ser_data, load_strobe, rf_lk, if_lk, obs, fast;
   logic rf_n = 0, rf_r = 0, if_n = 0, if_r = 0, ref_d = 0, fast_m = 0, rf_stb = 0, if_stb = 0;
   logic [7:0] rf_err = 8'hFF, if_err = 8'hFF;
   sslp_word_t l0, l1, l2, l3, w;
   sslp_word_t mir [4] = '{default: 24'h000000};
   sslp_word_t q [$];
   logic [95:0] prev = '0;
   logic [95:0] cat;
   logic [1:0] cnt [2] = '{2'h0, 2'h0};
   logic lk [2] = '{1'b0, 1'b0};
   logic [3:0] os, fs;
   int bad_count = 0;
   int samples_checked = 0;
   bit watch = 0;
   logic [7:0] lst [8] = '{8'h0E, 8'h0E, 8'h0F, 8'h0E, 8'h0E, 8'h0E, 8'h19, 8'h1A};
   assign cat = {l3, l2, l1, l0};
   sslp_host_model sslp_host_model_i (.ser_clk_out(ser_clk), .ser_data_out(ser_data), .load_strobe_out(load_strobe));
   sslp_port sslp_port_i (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .ser_clk_in(ser_clk), .ser_data_in(ser_data),
      .load_strobe_in(load_strobe), .rf_ndiv_in(rf_n), .rf_rdiv_in(rf_r), .if_ndiv_in(if_n), .if_rdiv_in(if_r),
      .ref_div_in(ref_d), .fast_mode_in(fast_m), .rf_pd_strobe_in(rf_stb), .rf_pd_err_in(rf_err),
      .if_pd_strobe_in(if_stb), .if_pd_err_in(if_err), .if_ref_latch_out(l0), .if_fb_latch_out(l1),
      .rf_ref_latch_out(l2), .rf_fb_latch_out(l3), .rf_lock_out(rf_lk), .if_lock_out(if_lk),
      .observe_output_out(obs), .fast_settle_output_out(fast));
   initial forever #12.5 mclk_in = ~mclk_in;
   // ----------------------------------------
   // Checking tasks
   // ----------------------------------------
   task automatic summarize();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic check_word(input sslp_word_t got, input sslp_word_t exp);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %0t latch %h want %h", $time, got, exp);
      end
   endtask
   task automatic check_bit(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %0t pin %b want %b", $time, got, exp);
      end
   endtask
   task automatic tick();
      @(posedge mclk_in);
      #2;
   endtask
   // Any latch change must match the oldest pending load, and the other three must hold
   always @(posedge mclk_in) begin
      prev <= cat;
      if (watch && cat !== prev) begin
         if (q.size() == 0) begin
            bad_count++;
            $display("CHECK FAILED %0t latch changed without a load", $time);
         end else begin
            w = q.pop_front();
            mir[w[1:0]] = w;
         end
         for (int i = 0; i < 4; i++) check_word(cat[i*24+:24], mir[i]);
      end
   end
   // ----------------------------------------
   // Stimulus tasks
   // ----------------------------------------
   task automatic load(input logic [1:0] sel, input logic [21:0] pay, input int low_ns);
      int n;
      sslp_word_t v;
      v = {pay, sel};
      // A repeat of the held value would be invisible, so one payload bit is turned
      if (v == mir[sel]) v[2] = ~v[2];
      q.push_back(v);
      sslp_host_model_i.send(v, low_ns, 1'b1);
      n = 0;
      while (q.size() != 0 && n < 40) begin
         tick();
         n++;
      end
      if (n == 40) begin
         bad_count++;
         $display("CHECK FAILED %0t load never reached a latch", $time);
         summarize();
      end
   endtask
   task automatic pd(input logic [7:0] e, input logic [1:0] on);
      rf_stb = on[0];
      if_stb = on[1];
      rf_err = e;
      if_err = e;
      for (int c = 0; c < 2; c++) if (on[c]) begin
         if (e > 8'h19) lk[c] = 1'b0;
         cnt[c] = (e >= 8'h0F) ? 2'h0 : (cnt[c] == 2'h3) ? 2'h3 : cnt[c] + 2'h1;
         if (cnt[c] == 2'h3) lk[c] = 1'b1;
      end
      tick();
      rf_stb = 1'b0;
      if_stb = 1'b0;
      // Error values without a strobe must be ignored
      rf_err = 8'($urandom);
      if_err = 8'($urandom);
      tick();
      check_bit(rf_lk, lk[0]);
      check_bit(if_lk, lk[1]);
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      void'($urandom(32'hd3b5));
      repeat (12) @(posedge mclk_in);
      #2 sys_rst_in = 1'b0;
      repeat (5) tick();
      watch = 1;
      for (int i = 0; i < 4; i++) check_word(cat[i*24+:24], 24'h000000);
      check_bit(obs, 1'b0);
      for (int i = 0; i < 8; i++) begin
         if (i == 5) sslp_host_model_i.send(24'hA5A5A7, 100, 1'b0);
         load(i[1:0], 22'($urandom), (i % 2) ? 400 : 100);
      end
      for (int i = 0; i < 8; i++) pd(lst[i], 2'h3);
      for (int i = 0; i < 60; i++) pd(8'($urandom_range(0, 40)), 2'($urandom));
      for (int i = 0; i < 5; i++) begin
         load(2'h0, {i[1:0], i[2], i[1:0], 17'($urandom)}, 100);
         repeat (6) begin
            {rf_n, rf_r, if_n, if_r, ref_d, fast_m} = 6'($urandom);
            os = {ref_d, if_n, rf_n, lk[i[2]]};
            fs = {if_r, rf_r, rf_n, fast_m};
            tick();
            check_bit(obs, os[i[1:0]]);
            check_bit(fast, fs[i[1:0]]);
         end
      end
      summarize();
   end
endmodule // testbench
